/* hw/cantxb_pkg.sv */
// transmit buffer element package: layout, config fields, register map
// assumes nothing beyond a systemverilog package scope
package cantxb_pkg;
  // element word 0
  localparam int T0_ESI_BIT  = 31;
  localparam int T0_XTD_BIT  = 30;
  localparam int T0_RTR_BIT  = 29;
  localparam int T0_ID_MSB   = 28;
  localparam int T0_STD_LSB  = 18;
  // element word 1
  localparam int T1_MM_MSB   = 31;
  localparam int T1_MM_LSB   = 24;
  localparam int T1_EFC_BIT  = 23;
  localparam int T1_FDF_BIT  = 21;
  localparam int T1_BRS_BIT  = 20;
  localparam int T1_DLC_MSB  = 19;
  localparam int T1_DLC_LSB  = 16;
  localparam int HDR_WORDS   = 2;
  localparam int MAX_DATA    = 64;
  // register byte addresses
  localparam logic [7:0] REG_BUF_CFG  = 8'h00;
  localparam logic [7:0] REG_ESZ_CFG  = 8'h04;
  localparam logic [7:0] REG_CTRL     = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_EVENT    = 8'h10;
  localparam logic [7:0] REG_MEM_BASE = 8'h80;
  // buf cfg fields
  localparam int CFG_DED_LSB  = 0;
  localparam int CFG_FQS_LSB  = 8;
  localparam int CFG_W        = 6;
  // ctrl bits
  localparam int CTRL_FD_OPERATION_ENABLE    = 0;
  localparam int CTRL_START   = 1;
  localparam int CTRL_IDX_LSB = 8;
  // status bits
  localparam int ST_BUSY      = 0;
  localparam int ST_DED       = 1;
  localparam int ST_ERRP      = 2;
  localparam int ST_EVT       = 3;
  localparam int ST_BAD       = 4;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    CTB_IDLE = 2'b00,
    CTB_HDR0 = 2'b01,
    CTB_HDR1 = 2'b10,
    CTB_DATA = 2'b11
  } cantxb_state_t;
  // data bytes carried by a data length code
  function automatic logic [6:0] cantxb_dlc_bytes(input logic [3:0] dlc, input logic fd);
    logic [6:0] n;
    n = 7'h00;
    if (dlc <= 4'h8 || !fd) begin
      n = (dlc > 4'h8) ? 7'h08 : {3'h0, dlc};
    end else begin
      case (dlc)
        4'h9: n = 7'h0c;
        4'ha: n = 7'h10;
        4'hb: n = 7'h14;
        4'hc: n = 7'h18;
        4'hd: n = 7'h20;
        4'he: n = 7'h30;
        default: n = 7'h40;
      endcase
    end
    return n;
  endfunction : cantxb_dlc_bytes
  // data words of an element for a configured data field size code
  function automatic logic [4:0] cantxb_esz_words(input logic [2:0] esz);
    logic [4:0] w;
    w = 5'h00;
    case (esz)
      3'h0: w = 5'h02;
      3'h1: w = 5'h03;
      3'h2: w = 5'h04;
      3'h3: w = 5'h05;
      3'h4: w = 5'h06;
      3'h5: w = 5'h08;
      3'h6: w = 5'h0c;
      default: w = 5'h10;
    endcase
    return w;
  endfunction : cantxb_esz_words
endpackage : cantxb_pkg

/* hw/cantxb_mem.sv */
// small message memory, one write port, one registered read port
// assumes single clock, synchronous use only
`timescale 1ns/1ps
module cantxb_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  initial begin
    if (DEPTH > (1 << AW)) $error("depth exceeds address width");
  end
  logic [31:0] mem [DEPTH];
  always_ff @(posedge aclk) begin
    if (we) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb[b]) mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
    rdata <= mem[raddr];
  end
endmodule : cantxb_mem

/* hw/cantxb_top.sv */
// transmit buffer element handler: axi4-lite registers and element memory,
// parses a chosen element and streams the frame fields to the protocol engine
// assumes one 20 mhz clock, engine signals synchronous to it
//
// How it works
// - dedicated buffers sit first in the area and fifo/queue buffers follow them.
// - a buffer is classed dedicated or fifo/queue from the dedicated count alone.
// - element size is set by a size field so an element can carry 64 data bytes.
// - word 0 gives the error state control at bit 31 and the identifier at bits 28:0.
// - the sent fd esi bit is the element esi or-ed with the error passive flag.
// - bit 30 of word 0 picks an 11-bit standard or a 29-bit extended identifier.
// - bit 29 of word 0 picks a data frame when 0 and a remote frame when 1.
// - a remote frame is always sent in classic format even with fd enabled.
// - the marker in word 1 bits 31:24 is copied into the transmit event entry.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module cantxb_top
  import cantxb_pkg::*;
#(
  parameter int MEM_WORDS = 128,
  parameter int MEM_AW    = 7
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [8:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        error_passive,
  output logic             frm_valid,
  input  wire logic        frm_ready,
  output logic [28:0]      frm_id,
  output logic             frm_ext,
  output logic             frm_remote,
  output logic             frm_fd,
  output logic             frm_brs,
  output logic             frm_esi,
  output logic [3:0]       frm_dlc,
  output logic             dat_valid,
  input  wire logic        dat_ready,
  output logic [7:0]       dat_byte,
  output logic             dat_last,
  output logic             evt_valid,
  output logic [7:0]       evt_marker
);
  initial begin
    if (MEM_WORDS > (1 << MEM_AW) || MEM_WORDS < 16) $error("bad memory size");
  end
  // register state
  logic [CFG_W-1:0] ded_count;
  logic [CFG_W-1:0] fq_size;
  logic [2:0]       esz;
  logic             fd_operation_enable;
  logic [5:0]       sel_idx;
  logic             bad_sel;
  logic             evt_seen;
  logic             is_ded;
  cantxb_state_t    state;
  // element working copy
  logic [31:0]      w0;
  logic [6:0]       nbytes;
  logic [6:0]       bcnt;
  logic [MEM_AW-1:0] rd_ptr;
  logic [31:0]      mem_rdata;
  logic             dat_word_ok;
  // axi write capture
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_q;
  logic [31:0]      w_q;
  logic [3:0]       ws_q;
  wire              aw_take   = s_axi_awvalid && s_axi_awready;
  wire              w_take    = s_axi_wvalid && s_axi_wready;
  wire              wr_go     = aw_held && w_held && !s_axi_bvalid;
  wire              wr_mem    = wr_go && aw_q[7];
  wire              wr_cfg    = wr_go && (aw_q == REG_BUF_CFG);
  wire              wr_esz    = wr_go && (aw_q == REG_ESZ_CFG);
  wire              wr_ctrl   = wr_go && (aw_q == REG_CTRL);
  wire              wr_evt    = wr_go && (aw_q == REG_EVENT);
  wire              wr_known  = wr_mem || wr_cfg || wr_esz || wr_ctrl || wr_evt;
  wire              start_req = wr_ctrl && w_q[CTRL_START] && state == CTB_IDLE;
  wire [5:0]        req_idx   = w_q[CTRL_IDX_LSB +: 6];
  wire [6:0]        area_bufs = {1'b0, ded_count} + {1'b0, fq_size};
  // element words: two header words plus the configured data words
  wire [4:0]        elem_w    = cantxb_esz_words(esz) + 5'(HDR_WORDS);
  // dedicated buffers first, fifo/queue after
  wire              req_ded   = req_idx < ded_count;
  wire              req_ok    = {1'b0, req_idx} < area_bufs;
  wire [11:0]       elem_base = 12'(req_idx) * 12'(elem_w);
  wire              base_fit  = (elem_base + 12'(elem_w)) <= 12'(MEM_WORDS);
  wire              mem_rd_sel = (state == CTB_IDLE) && !s_axi_rvalid;
  wire [MEM_AW-1:0] rd_addr   = mem_rd_sel ? MEM_AW'(s_axi_araddr[6:2]) : rd_ptr;
  wire [7:0]        cur_byte  = mem_rdata[8*bcnt[1:0] +: 8];
  wire              dat_fire  = dat_valid && dat_ready;
  wire              frm_fire  = frm_valid && frm_ready;
  wire              byte_fit  = nbytes <= 7'({elem_w - 5'(HDR_WORDS), 2'b00});
  cantxb_mem #(.DEPTH(MEM_WORDS), .AW(MEM_AW)) u_mem (
    .aclk  (aclk),
    .we    (wr_mem),
    .waddr (MEM_AW'(aw_q[6:2])),
    .wdata (w_q),
    .wstrb (ws_q),
    .raddr (rd_addr),
    .rdata (mem_rdata)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_take;
      s_axi_wready <= !w_held && !w_take;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // read path: memory reads are one cycle late, registers ride along
  logic        rd_pend;
  logic [8:0]  ar_q;
  wire         ar_take = s_axi_arvalid && s_axi_arready;
  wire [31:0]  status_w = {27'h0, bad_sel, evt_seen, error_passive, is_ded,
                           state != CTB_IDLE};
  wire [31:0]  reg_rd =
    (ar_q[7:0] == REG_BUF_CFG) ? {18'h0, fq_size, 2'b00, ded_count} :
    (ar_q[7:0] == REG_ESZ_CFG) ? {29'h0, esz} :
    (ar_q[7:0] == REG_CTRL)    ? {18'h0, sel_idx, 7'h00, fd_operation_enable} :
    (ar_q[7:0] == REG_STATUS)  ? status_w :
    (ar_q[7:0] == REG_EVENT)   ? {24'h0, evt_marker} : 32'h0000_0000;
  wire         rd_known = ar_q[7] || (ar_q[7:0] <= REG_EVENT);
  wire         rd_ok    = rd_known && !ar_q[8];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rd_pend <= 1'b0;
      ar_q <= 9'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= mem_rd_sel && !rd_pend && !ar_take;
      if (ar_take) begin
        rd_pend <= 1'b1;
        ar_q <= s_axi_araddr;
      end else if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= !rd_ok ? 32'h0000_0000 : ar_q[7] ? mem_rdata : reg_rd;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // configuration and status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ded_count <= '0;
      fq_size <= '0;
      esz <= 3'h0;
      fd_operation_enable <= 1'b0;
      sel_idx <= 6'h00;
      bad_sel <= 1'b0;
      is_ded <= 1'b0;
      evt_seen <= 1'b0;
    end else begin
      if (wr_cfg) begin
        ded_count <= w_q[CFG_DED_LSB +: CFG_W];
        fq_size <= w_q[CFG_FQS_LSB +: CFG_W];
      end
      if (wr_esz) esz <= w_q[2:0];
      if (wr_ctrl) begin
        fd_operation_enable <= w_q[CTRL_FD_OPERATION_ENABLE];
        sel_idx <= req_idx;
      end
      if (start_req) begin
        bad_sel <= !(req_ok && base_fit);
        is_ded <= req_ded;
      end
      // new event wins over a software clear
      if (evt_valid) evt_seen <= 1'b1;
      else if (wr_evt) evt_seen <= 1'b0;
    end
  end
  // element walk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CTB_IDLE;
      rd_ptr <= '0;
      w0 <= 32'h0000_0000;
      nbytes <= 7'h00;
      bcnt <= 7'h00;
      dat_word_ok <= 1'b0;
      frm_valid <= 1'b0;
      frm_id <= 29'h0;
      frm_ext <= 1'b0;
      frm_remote <= 1'b0;
      frm_fd <= 1'b0;
      frm_brs <= 1'b0;
      frm_esi <= 1'b0;
      frm_dlc <= 4'h0;
      dat_valid <= 1'b0;
      dat_byte <= 8'h00;
      dat_last <= 1'b0;
      evt_valid <= 1'b0;
      evt_marker <= 8'h00;
    end else begin
      evt_valid <= 1'b0;
      case (state)
        CTB_IDLE: begin
          if (start_req && req_ok && base_fit) begin
            rd_ptr <= MEM_AW'(elem_base);
            state <= CTB_HDR0;
          end
        end
        CTB_HDR0: begin
          rd_ptr <= rd_ptr + MEM_AW'(1);
          state <= CTB_HDR1;
        end
        CTB_HDR1: begin
          if (!frm_valid && !dat_valid && w0 == 32'h0 && bcnt == 7'h00) begin
            w0 <= mem_rdata;
            rd_ptr <= rd_ptr + MEM_AW'(1);
            bcnt <= 7'h01;
          end else if (!frm_valid && bcnt == 7'h01) begin
            frm_valid <= 1'b1;
            frm_ext <= w0[T0_XTD_BIT];
            // standard id lives in 28:18
            frm_id <= w0[T0_XTD_BIT] ? w0[T0_ID_MSB:0] :
                      {18'h0, w0[T0_ID_MSB:T0_STD_LSB]};
            frm_remote <= w0[T0_RTR_BIT];
            frm_fd <= fd_operation_enable && mem_rdata[T1_FDF_BIT] && !w0[T0_RTR_BIT];
            frm_brs <= fd_operation_enable && mem_rdata[T1_BRS_BIT] && !w0[T0_RTR_BIT];
            frm_esi <= w0[T0_ESI_BIT] | error_passive;
            frm_dlc <= mem_rdata[T1_DLC_MSB:T1_DLC_LSB];
            evt_marker <= mem_rdata[T1_MM_MSB:T1_MM_LSB];
            dat_last <= mem_rdata[T1_EFC_BIT];
            nbytes <= w0[T0_RTR_BIT] ? 7'h00 :
                      cantxb_dlc_bytes(mem_rdata[T1_DLC_MSB:T1_DLC_LSB],
                                       fd_operation_enable && mem_rdata[T1_FDF_BIT]);
          end else if (frm_fire) begin
            frm_valid <= 1'b0;
            bcnt <= 7'h00;
            dat_word_ok <= 1'b0;
            // dat_last carried the event request during the header
            if (dat_last) evt_valid <= 1'b1;
            dat_last <= 1'b0;
            if (nbytes == 7'h00 || !byte_fit) begin
              state <= CTB_IDLE;
              w0 <= 32'h0;
            end else begin
              state <= CTB_DATA;
            end
          end
        end
        default: begin
          if (!dat_word_ok) begin
            dat_word_ok <= 1'b1;
          end else if (!dat_valid || dat_fire) begin
            if (dat_fire && bcnt == nbytes) begin
              dat_valid <= 1'b0;
              state <= CTB_IDLE;
              w0 <= 32'h0;
              bcnt <= 7'h00;
            end else if (dat_fire && bcnt[1:0] == 2'b00) begin
              dat_valid <= 1'b0;
              dat_word_ok <= 1'b0;
              rd_ptr <= rd_ptr + MEM_AW'(1);
            end else begin
              dat_valid <= 1'b1;
              dat_byte <= cur_byte;
              dat_last <= (bcnt + 7'h01) == nbytes;
              bcnt <= bcnt + 7'h01;
            end
          end
        end
      endcase
    end
  end
endmodule : cantxb_top

/* bench/cantxb_top_asserts.sv */
// checker: frame, byte stream and read answer rules at top ports
// assumes bind onto cantxb_top, one clock domain
`timescale 1ns/1ps
module cantxb_top_asserts
  import cantxb_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        error_passive,
  input wire logic        frm_valid,
  input wire logic        frm_ready,
  input wire logic [28:0] frm_id,
  input wire logic        frm_ext,
  input wire logic        frm_remote,
  input wire logic        frm_fd,
  input wire logic        frm_brs,
  input wire logic        frm_esi,
  input wire logic        dat_valid,
  input wire logic        dat_ready,
  input wire logic [7:0]  dat_byte,
  input wire logic        evt_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_FRM_HOLD: assert property (frm_valid && !frm_ready |=>
    frm_valid && $stable(frm_id)) else $error("frame header dropped");
  AST_FRM_FLAGS: assert property (frm_valid && !frm_ready |=>
    $stable({frm_ext, frm_fd, frm_brs})) else $error("frame flags moved");
  AST_STD_ID: assert property (frm_valid && !frm_ext |->
    frm_id[28:11] == 18'h0) else $error("standard id too wide");
  AST_REM_CLASSIC: assert property (frm_valid && frm_remote |->
    !frm_fd && !frm_brs) else $error("remote frame not classic");
  AST_REM_NODATA: assert property (frm_valid && frm_ready && frm_remote |=>
    !dat_valid [*4]) else $error("remote frame sent data");
  AST_ESI_OR: assert property (frm_valid && frm_fd && error_passive |->
    frm_esi) else $error("esi not forced by error passive");
  AST_DAT_HOLD: assert property (dat_valid && !dat_ready |=>
    dat_valid && $stable(dat_byte)) else $error("data byte dropped");
  AST_EVT_PULSE: assert property (evt_valid |=> !evt_valid)
    else $error("event pulse too long");
  AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("refused read data not zero");
endmodule : cantxb_top_asserts

bind cantxb_top cantxb_top_asserts cantxb_top_asserts_inst (.aclk(aclk),
  .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .error_passive(error_passive), .frm_valid(frm_valid),
  .frm_ready(frm_ready), .frm_id(frm_id), .frm_ext(frm_ext), .frm_remote(frm_remote),
  .frm_fd(frm_fd), .frm_brs(frm_brs), .frm_esi(frm_esi), .dat_valid(dat_valid),
  .dat_ready(dat_ready), .dat_byte(dat_byte), .evt_valid(evt_valid));

/* bench/cantxb_engine.sv */
// protocol engine stand-in: takes headers and bytes, records them
// assumes the top's frame and byte handshakes on one clock
`timescale 1ns/1ps
module cantxb_engine (
  input  wire logic        aclk,
  input  wire logic        slow,
  input  wire logic        frm_valid,
  input  wire logic [28:0] frm_id,
  input  wire logic [3:0]  flags,
  input  wire logic [3:0]  frm_dlc,
  input  wire logic        frm_brs,
  input  wire logic        dat_last,
  input  wire logic        dat_valid,
  input  wire logic [7:0]  dat_byte,
  input  wire logic        evt_valid,
  input  wire logic [7:0]  evt_marker,
  output logic             frm_ready,
  output logic             dat_ready
);
  logic [1:0]  cnt = 2'h0;
  logic [28:0] c_id;
  logic [3:0]  c_flg;
  logic [3:0]  c_dlc;
  logic [7:0]  c_mm;
  logic        c_brs;
  int          last_pos = 0;
  logic [7:0]  rx_q[$];
  int          n_frm = 0;
  int          n_evt = 0;
  // slow mode stalls both handshakes
  assign frm_ready = !slow || cnt == 2'h3;
  assign dat_ready = !slow || cnt[0];
  always @(posedge aclk) begin
    cnt <= cnt + 2'h1;
    if (frm_valid && frm_ready) begin
      c_id <= frm_id;
      c_flg <= flags;
      c_dlc <= frm_dlc;
      c_brs <= frm_brs;
      last_pos <= 0;
      n_frm <= n_frm + 1;
    end
    if (dat_valid && dat_ready) rx_q.push_back(dat_byte);
    // position of the byte flagged last, counted from one
    if (dat_valid && dat_ready && dat_last) last_pos <= rx_q.size();
    if (evt_valid) begin
      c_mm <= evt_marker;
      n_evt <= n_evt + 1;
    end
  end
endmodule : cantxb_engine

/* bench/test_cantxb_top.sv */
// testbench: element rows through the frame path, then awkward cases
// assumes cantxb_top, checker bind and engine model compiled before
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module test_cantxb_top
  import cantxb_pkg::*;
;
  typedef struct {
    logic [5:0] idx; logic [31:0] w0; logic [31:0] w1; logic ep;
    logic [28:0] id; logic [3:0] flg; int nb;
  } cantxb_row_t;
  cantxb_row_t rows[6] = '{
    '{6'd0, 32'h048c0000, 32'h00040000, 1'b0, 29'h123, 4'h0, 4},
    '{6'd1, 32'h41abcdef, 32'h5ab80000, 1'b0, 29'h1abcdef, 4'ha, 8},
    '{6'd2, 32'h9ffc0000, 32'h00220000, 1'b0, 29'h7ff, 4'h3, 2},
    '{6'd3, 32'h00040000, 32'h00210000, 1'b1, 29'h1, 4'h3, 1},
    '{6'd0, 32'h248c0000, 32'h00330000, 1'b0, 29'h123, 4'h4, 0},
    '{6'd1, 32'h00140000, 32'h000c0000, 1'b0, 29'h5, 4'h0, 8}};
  logic        aclk = 1'b0, aresetn = 1'b0, ep = 1'b0, slow = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [8:0]  araddr = 9'h000;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic        frm_valid, frm_ready, frm_ext, frm_remote, frm_fd, frm_brs, frm_esi;
  logic        dat_valid, dat_ready, dat_last, evt_valid;
  logic [28:0] frm_id;
  logic [3:0]  frm_dlc;
  logic [7:0]  dat_byte, evt_marker;
  int          mismatches = 0, n_checks = 0, f;
  cantxb_top cantxb_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .error_passive(ep), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_id(frm_id), .frm_ext(frm_ext), .frm_remote(frm_remote),
    .frm_fd(frm_fd), .frm_brs(frm_brs), .frm_esi(frm_esi), .frm_dlc(frm_dlc),
    .dat_valid(dat_valid), .dat_ready(dat_ready), .dat_byte(dat_byte),
    .dat_last(dat_last), .evt_valid(evt_valid), .evt_marker(evt_marker));
  cantxb_engine cantxb_engine_inst (.aclk(aclk), .slow(slow), .frm_valid(frm_valid),
    .frm_id(frm_id), .flags({frm_ext, frm_remote, frm_fd, frm_esi}), .frm_dlc(frm_dlc),
    .frm_brs(frm_brs), .dat_last(dat_last),
    .dat_valid(dat_valid), .dat_byte(dat_byte), .evt_valid(evt_valid),
    .evt_marker(evt_marker), .frm_ready(frm_ready), .dat_ready(dat_ready));
  initial forever #25 aclk = ~aclk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic load(input int idx, input logic [31:0] w0, w1, input int nd, ew);
    logic [7:0] b;
    b = 8'h80 + 8'(idx * ew * 4);
    wr(b, w0, rs);
    wr(b + 8'h04, w1, rs);
    for (int k = 0; k < nd; k++) wr(b + 8'(8 + 4 * k), 32'h03020100 + 32'h04040404 * k, rs);
  endtask : load
  task automatic fire(input logic [5:0] idx, input int nb, input logic fd = 1'b1);
    f = cantxb_engine_inst.n_frm;
    cantxb_engine_inst.rx_q.delete();
    wr(REG_CTRL, {18'h0, idx, 6'h00, 1'b1, fd}, rs);
    while (cantxb_engine_inst.n_frm == f) @(posedge aclk);
    while (cantxb_engine_inst.rx_q.size() < nb) @(posedge aclk);
    repeat (8) @(posedge aclk);
    `CHK("byte count", nb, cantxb_engine_inst.rx_q.size())
    `CHK("last", nb, cantxb_engine_inst.last_pos)
    for (int k = 0; k < nb; k++) `CHK("byte", 8'(k), cantxb_engine_inst.rx_q[k])
  endtask : fire
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (11) @(posedge aclk);
    `CHK("reset outs", 4'h0, {frm_valid, dat_valid, bvalid, evt_valid})
    @(posedge aclk);
    aresetn <= 1'b1;
    $display("reset test done");
    wr(REG_BUF_CFG, 32'h00000202, rs);
    wr(REG_ESZ_CFG, 32'h0, rs);
    for (int i = 0; i < 6; i++) begin
      ep <= rows[i].ep;
      load(rows[i].idx, rows[i].w0, rows[i].w1, 2, 4);
      fire(rows[i].idx, rows[i].nb);
      `CHK("id", rows[i].id, cantxb_engine_inst.c_id)
      `CHK("flags", rows[i].flg[3:1], cantxb_engine_inst.c_flg[3:1])
      if (rows[i].flg[1]) `CHK("esi", rows[i].flg[0], cantxb_engine_inst.c_flg[0])
      `CHK("dlc", rows[i].w1[19:16], cantxb_engine_inst.c_dlc)
      `CHK("brs", rows[i].w1[20] & ~rows[i].w0[29], cantxb_engine_inst.c_brs)
      rd({1'b0, REG_STATUS}, rv, rs);
      `CHK("dedicated", rows[i].idx < 6'd2, rv[ST_DED])
      $display("row %0d done", i);
    end
    rd({1'b0, REG_EVENT}, rv, rs);
    `CHK("marker reg", rows[5].w1[31:24], rv[7:0])
    `CHK("marker out", 8'h5a, cantxb_engine_inst.c_mm)
    `CHK("events", 1, cantxb_engine_inst.n_evt)
    $display("event test done");
    load(1, 32'h00140000, 32'h00390000, 2, 4);
    fire(6'd1, 8, 1'b0);
    `CHK("fd off", 2'b00, {cantxb_engine_inst.c_flg[1], cantxb_engine_inst.c_brs})
    $display("fd off test done");
    f = cantxb_engine_inst.n_frm;
    wr(REG_CTRL, 32'h00000403, rs);
    repeat (20) @(posedge aclk);
    rd({1'b0, REG_STATUS}, rv, rs);
    `CHK("bad index", 1'b1, rv[ST_BAD])
    `CHK("no frame", f, cantxb_engine_inst.n_frm)
    $display("bad index test done");
    slow <= 1'b1;
    wr(REG_ESZ_CFG, 32'h7, rs);
    load(0, 32'h00040000, 32'h002f0000, 16, 18);
    fire(6'd0, 64);
    slow <= 1'b0;
    $display("long element test done");
    rd(9'h040, rv, rs);
    `CHK("gap resp", RESP_SLVERR, rs)
    `CHK("gap data", 32'h0, rv)
    rd(9'h100, rv, rs);
    `CHK("high resp", RESP_SLVERR, rs)
    wr(8'h40, 32'h1, rs);
    `CHK("gap write", RESP_SLVERR, rs)
    $display("unmapped test done");
    wrap_up();
  end
endmodule : test_cantxb_top
